// ---- src/afbt_defs.vh ----
/*
 flash bus host controller constants: timing figures in ns and derived cycle counts.
 assumes a 250 MHz mclk (4 ns period).
*/
`ifndef AFBT_DEFS_VH
`define AFBT_DEFS_VH
`define AFBT_CLK_NS          4
`define AFBT_ADDR_ACC_NS     75
`define AFBT_OE_ACC_NS       25
`define AFBT_PAGE_ACC_NS     25
`define AFBT_OE_FLOAT_NS     15
`define AFBT_CE_FLOAT_NS     25
`define AFBT_RST_REC_NS      210
`define AFBT_BYTE_SW_NS      1000
`define AFBT_STROBE_ACT_NS   60
`define AFBT_STROBE_INACT_NS 30
`define AFBT_ADDR_SETUP_NS   55
`define AFBT_WR_REC_NS       35
`define AFBT_RST_LOW_NS      100
`define AFBT_STS_WAIT_NS     500
`define AFBT_CYC(ns) ((((ns) + `AFBT_CLK_NS - 1) / `AFBT_CLK_NS) < 1 ? 1 : \
  (((ns) + `AFBT_CLK_NS - 1) / `AFBT_CLK_NS))
`define AFBT_ADDR_ACC_CYC     `AFBT_CYC(`AFBT_ADDR_ACC_NS)
`define AFBT_PAGE_ACC_CYC     `AFBT_CYC(`AFBT_PAGE_ACC_NS)
`define AFBT_FLOAT_CYC        `AFBT_CYC(`AFBT_CE_FLOAT_NS)
`define AFBT_RST_REC_CYC      `AFBT_CYC(`AFBT_RST_REC_NS)
`define AFBT_BYTE_SW_CYC      `AFBT_CYC(`AFBT_BYTE_SW_NS)
`define AFBT_STROBE_ACT_CYC   `AFBT_CYC(`AFBT_STROBE_ACT_NS)
`define AFBT_STROBE_INACT_CYC `AFBT_CYC(`AFBT_STROBE_INACT_NS)
`define AFBT_WR_REC_CYC       `AFBT_CYC(`AFBT_WR_REC_NS)
`define AFBT_RST_LOW_CYC      `AFBT_CYC(`AFBT_RST_LOW_NS)
`define AFBT_STS_WAIT_CYC     `AFBT_CYC(`AFBT_STS_WAIT_NS)
`define AFBT_PAGE_WORDS       8
`define AFBT_SEL_ON           3'b000
`define AFBT_SEL_OFF          3'b001
`endif

// ---- src/afbt_host.v ----
/*
 host controller driving an asynchronous nor flash bus: reads, 8-word page reads,
 writes, reset pulse and ready/busy wait. assumes one request at a time from
 same-clock user logic and the flash pins wired directly to the ports.
*/
`timescale 1ns/1ps
`include "afbt_defs.vh"
module afbt_host
(
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire        req_page,
  input  wire        req_std_mode,
  input  wire        req_byte_mode,
  input  wire        req_reset,
  input  wire [23:0] req_addr,
  input  wire [15:0] req_wdata,
  input  wire        prog_enable_req,
  output wire        req_ready,
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  output reg         busy_status,
  output reg  [23:0] flash_addr,
  output reg  [15:0] flash_dq_o,
  output reg         flash_dq_oe_n,
  input  wire [15:0] flash_dq_i,
  output reg  [2:0]  select_combination,
  output reg         flash_oe_n,
  output reg         flash_we_n,
  output reg         flash_byte_n,
  output reg         reset_powerdown_n,
  output reg         program_enable_input,
  input  wire        ready_status_pin
);
  localparam ST_IDLE  = 9'b000000001;
  localparam ST_RACC  = 9'b000000010;
  localparam ST_RPAGE = 9'b000000100;
  localparam ST_FLOAT = 9'b000001000;
  localparam ST_WLOW  = 9'b000010000;
  localparam ST_WHIGH = 9'b000100000;
  localparam ST_RSTLO = 9'b001000000;
  localparam ST_RSTRC = 9'b010000000;
  localparam ST_BYTE  = 9'b100000000;

  // cycle end points, sliced to the counter widths below
  localparam [31:0] BYTE_END  = `AFBT_BYTE_SW_CYC - 1;
  localparam [31:0] ACC_END   = `AFBT_ADDR_ACC_CYC + 1;
  localparam [31:0] PAGE_END  = `AFBT_PAGE_ACC_CYC + 1;
  localparam [31:0] FLOAT_END = `AFBT_FLOAT_CYC - 1;
  localparam [31:0] WLOW_END  = `AFBT_STROBE_ACT_CYC - 1;
  localparam [31:0] WHIGH_END = `AFBT_STROBE_INACT_CYC - 1;
  localparam [31:0] RSTLO_END = `AFBT_RST_LOW_CYC - 1;
  localparam [31:0] RSTRC_END = `AFBT_RST_REC_CYC - 1;
  localparam [31:0] STS_LOAD  = `AFBT_STS_WAIT_CYC;
  localparam [31:0] REC_LOAD  = `AFBT_WR_REC_CYC;

  reg  [8:0]  state_q;
  reg  [8:0]  cnt_q;
  reg  [2:0]  word_q;
  reg  [8:0]  rec_q;
  reg  [15:0] dq_s1_q;
  reg  [15:0] dq_s2_q;
  reg         sts_s1_q;
  reg         sts_s2_q;
  reg         page_q;
  reg         std_q;
  reg  [7:0]  sts_wait_q;

  assign req_ready = (state_q == ST_IDLE) && (rec_q == 9'h000);

  // sample asynchronous pins through two flops
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dq_s1_q  <= 16'h0000;
      dq_s2_q  <= 16'h0000;
      sts_s1_q <= 1'b1;
      sts_s2_q <= 1'b1;
    end
    else
    begin
      dq_s1_q  <= flash_dq_i;
      dq_s2_q  <= dq_s1_q;
      sts_s1_q <= ready_status_pin;
      sts_s2_q <= sts_s1_q;
    end
  end

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q              <= ST_RSTLO;
      cnt_q                <= 9'h000;
      word_q               <= 3'h0;
      rec_q                <= 9'h000;
      page_q               <= 1'b0;
      std_q                <= 1'b0;
      sts_wait_q           <= 8'h00;
      rsp_valid            <= 1'b0;
      rsp_rdata            <= 16'h0000;
      busy_status          <= 1'b0;
      flash_addr           <= 24'h000000;
      flash_dq_o           <= 16'h0000;
      flash_dq_oe_n        <= 1'b1;
      select_combination   <= `AFBT_SEL_OFF;
      flash_oe_n           <= 1'b1;
      flash_we_n           <= 1'b1;
      flash_byte_n         <= 1'b1;
      reset_powerdown_n    <= 1'b0;
      program_enable_input <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (rec_q != 9'h000)
        rec_q <= rec_q - 9'h001;
      if (sts_wait_q != 8'h00)
        sts_wait_q <= sts_wait_q - 8'h01;
      busy_status <= (~sts_s2_q) || (sts_wait_q != 8'h00);
      program_enable_input <= prog_enable_req || program_enable_input && busy_status;
      case (state_q)
        ST_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            flash_addr <= req_addr;
            page_q     <= req_page;
            std_q      <= req_std_mode;
            word_q     <= 3'h0;
            if (req_reset)
            begin
              reset_powerdown_n <= 1'b0;
              cnt_q             <= 9'h000;
              state_q           <= ST_RSTLO;
            end
            else if (req_byte_mode != flash_byte_n)
            begin
              select_combination <= `AFBT_SEL_ON;
              flash_byte_n       <= req_byte_mode;
              cnt_q              <= 9'h000;
              state_q            <= ST_BYTE;
            end
            else if (req_write)
            begin
              // address, data and flash_we_n low all driven in the same cycle
              flash_dq_o         <= req_wdata;
              flash_dq_oe_n      <= 1'b0;
              select_combination <= `AFBT_SEL_ON;
              flash_oe_n         <= 1'b1;
              flash_we_n         <= 1'b0;
              cnt_q              <= 9'h000;
              state_q            <= ST_WLOW;
            end
            else
            begin
              select_combination <= `AFBT_SEL_ON;
              // oe with select, no lag needed
              flash_oe_n         <= 1'b0;
              flash_we_n         <= 1'b1;
              cnt_q              <= 9'h000;
              state_q            <= ST_RACC;
            end
          end
        end
        ST_BYTE:
        begin
          if (cnt_q == BYTE_END[8:0])
          begin
            select_combination <= `AFBT_SEL_OFF;
            rsp_valid          <= 1'b1;
            state_q            <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 9'h001;
        end
        ST_RACC:
        begin
          // full access plus two sync flops
          if (cnt_q == ACC_END[8:0])
          begin
            rsp_rdata <= dq_s2_q;
            rsp_valid <= 1'b1;
            cnt_q     <= 9'h000;
            if (page_q && word_q != 3'h7)
            begin
              word_q          <= word_q + 3'h1;
              flash_addr[2:0] <= word_q + 3'h1;
              state_q         <= ST_RPAGE;
            end
            else
            begin
              flash_oe_n         <= 1'b1;
              select_combination <= `AFBT_SEL_OFF;
              state_q            <= ST_FLOAT;
            end
          end
          else
            cnt_q <= cnt_q + 9'h001;
        end
        ST_RPAGE:
        begin
          // page step, full access in standard mode
          if (cnt_q == (std_q ? ACC_END[8:0] : PAGE_END[8:0]))
          begin
            rsp_rdata <= dq_s2_q;
            rsp_valid <= 1'b1;
            cnt_q     <= 9'h000;
            if (word_q != 3'h7)
            begin
              word_q          <= word_q + 3'h1;
              flash_addr[2:0] <= word_q + 3'h1;
            end
            else
            begin
              flash_oe_n         <= 1'b1;
              select_combination <= `AFBT_SEL_OFF;
              state_q            <= ST_FLOAT;
            end
          end
          else
            cnt_q <= cnt_q + 9'h001;
        end
        ST_FLOAT:
        begin
          if (cnt_q == FLOAT_END[8:0])
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q + 9'h001;
        end
        ST_WLOW:
        begin
          if (cnt_q == WLOW_END[8:0])
          begin
            flash_we_n <= 1'b1;
            cnt_q      <= 9'h000;
            sts_wait_q <= STS_LOAD[7:0];
            state_q    <= ST_WHIGH;
          end
          else
            cnt_q <= cnt_q + 9'h001;
        end
        ST_WHIGH:
        begin
          if (cnt_q == WHIGH_END[8:0])
          begin
            flash_dq_oe_n      <= 1'b1;
            select_combination <= `AFBT_SEL_OFF;
            rsp_valid          <= 1'b1;
            rec_q              <= REC_LOAD[8:0];
            state_q            <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 9'h001;
        end
        ST_RSTLO:
        begin
          if (cnt_q == RSTLO_END[8:0])
          begin
            reset_powerdown_n <= 1'b1;
            cnt_q             <= 9'h000;
            state_q           <= ST_RSTRC;
          end
          else
            cnt_q <= cnt_q + 9'h001;
        end
        ST_RSTRC:
        begin
          if (cnt_q == RSTRC_END[8:0])
          begin
            flash_byte_n <= 1'b1;
            rsp_valid    <= 1'b1;
            state_q      <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 9'h001;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // afbt_host

// ---- test/afbt_host_sva.sv ----
/*
 pin checker for afbt_host.
 assumes one mclk domain and sys_rst asynchronous active high.
*/
`timescale 1ns/1ps
module afbt_host_sva
(
  input wire        mclk,
  input wire        sys_rst,
  input wire        rsp_valid,
  input wire        busy_status,
  input wire [23:0] flash_addr,
  input wire [15:0] flash_dq_o,
  input wire        flash_dq_oe_n,
  input wire [2:0]  select_combination,
  input wire        flash_oe_n,
  input wire        flash_we_n,
  input wire        reset_powerdown_n,
  input wire        program_enable_input
);
  reg [4:0] wl_q;
  reg [5:0] rp_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      wl_q <= 5'h00;
      rp_q <= 6'h00;
    end
    else
    begin
      wl_q <= flash_we_n ? 5'h00 : wl_q + {4'h0, ~&wl_q};
      rp_q <= reset_powerdown_n ? rp_q + {5'h00, ~&rp_q} : 6'h00;
    end
  sequence quiet8;
    !rsp_valid [*8];
  endsequence
  a_sel_legal: assert property (select_combination == 3'b000 || select_combination == 3'b001)
    else $error("illegal select code");
  a_no_early_data: assert property ($fell(flash_oe_n) |-> quiet8 ##1 quiet8 ##1 !rsp_valid [*3])
    else $error("read answered too early");
  a_oe_float: assert property ($rose(flash_oe_n) |-> flash_dq_oe_n [*4])
    else $error("data driven during float");
  a_we_ends_strobe: assert property ($rose(flash_we_n) |-> select_combination == 3'b000)
    else $error("strobe not ended by write enable");
  a_we_width: assert property ($rose(flash_we_n) |-> wl_q >= 5'h0f)
    else $error("write strobe too short");
  a_we_gap: assert property ($rose(flash_we_n) |-> flash_we_n [*8])
    else $error("write strobe gap too short");
  a_wr_setup: assert property (!flash_we_n ##1 !flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved in strobe");
  a_wr_recov: assert property ($rose(flash_we_n) |-> flash_oe_n [*8] ##1 flash_oe_n)
    else $error("read too soon after write");
  a_rst_recov: assert property ($fell(flash_we_n) |-> rp_q >= 6'h35)
    else $error("write too soon after reset");
  a_pen_hold: assert property (program_enable_input && busy_status |=> program_enable_input)
    else $error("program enable dropped while busy");
  a_oe_we_excl: assert property (flash_oe_n || flash_we_n)
    else $error("output and write enable together");
endmodule // afbt_host_sva
bind afbt_host afbt_host_sva afbt_host_sva_i (.mclk, .sys_rst, .rsp_valid, .busy_status,
  .flash_addr, .flash_dq_o, .flash_dq_oe_n, .select_combination, .flash_oe_n, .flash_we_n,
  .reset_powerdown_n, .program_enable_input);

// ---- test/afbt_flash_model.sv ----
/*
 behavioural flash part for afbt_host, timing in ns.
 assumes host pins wired directly; 256 words modelled.
*/
`timescale 1ns/1ps
module afbt_flash_model
(
  input  wire [23:0] flash_addr,
  input  wire [15:0] flash_dq_o,
  input  wire [2:0]  select_combination,
  input  wire        flash_oe_n,
  input  wire        flash_we_n,
  input  wire        reset_powerdown_n,
  input  wire        std_mode,
  output reg  [15:0] flash_dq_i,
  output reg         ready_status_pin
);
  reg      [15:0] mem [0:255];
  realtime        t_hi, t_lo, t_sel, t_oe, t_rp;
  integer         i;
  // selected by the enabling code with reset_powerdown_n high
  wire sel = select_combination == 3'b000 && reset_powerdown_n;
  initial
  begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = i[15:0] ^ 16'h5a5a;
    ready_status_pin = 1'b1;
    flash_dq_i = 16'h0000;
    t_hi = 0;
    t_lo = 0;
    t_sel = 0;
    t_oe = 0;
    t_rp = 0;
  end
  always @(flash_addr[23:3]) t_hi = $realtime;
  always @(flash_addr[2:0]) t_lo = $realtime;
  always @(sel) t_sel = $realtime;
  always @(flash_oe_n) t_oe = $realtime;
  always @(reset_powerdown_n) t_rp = $realtime;
  // data after slowest path, else junk
  always #1
    if (!sel || flash_oe_n)
      flash_dq_i = ~flash_dq_i;
    else if ($realtime >= t_hi + 75 && $realtime >= t_lo + (std_mode ? 75 : 25)
             && $realtime >= t_sel + 75
             && $realtime >= t_oe + 25 && $realtime >= t_rp + 210)
      flash_dq_i = mem[flash_addr[7:0]];
    else
      flash_dq_i = ~mem[flash_addr[7:0]];
  // latch at strobe end, then ready/busy low a while
  always @(posedge flash_we_n)
    if (sel && flash_oe_n)
    begin
      mem[flash_addr[7:0]] = flash_dq_o;
      fork
        #200 ready_status_pin = 1'b0;
        #600 ready_status_pin = 1'b1;
      join_none
    end
endmodule // afbt_flash_model

// ---- test/test_async_flash_bus_timing.sv ----
/*
 self-checking bench for afbt_host with afbt_flash_model.
 assumes one 250 MHz clock; random traffic from a fixed lfsr.
*/
`timescale 1ns/1ps
module test_async_flash_bus_timing;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         req_valid = 1'b0;
  reg         req_write = 1'b0;
  reg         req_page = 1'b0;
  reg         req_std_mode = 1'b0;
  reg         req_reset = 1'b0;
  reg         req_byte_mode = 1'b1;
  reg  [23:0] req_addr = 24'h000000;
  reg  [15:0] req_wdata = 16'h0000;
  reg         prog_en = 1'b0;
  reg  [31:0] seed = 32'hea37f80f;
  reg  [15:0] shadow [0:255];
  reg  [7:0]  a;
  wire        req_ready, rsp_valid, busy_status, flash_dq_oe_n, flash_oe_n, flash_we_n;
  wire        flash_byte_n, reset_powerdown_n, program_enable_input, ready_status_pin;
  wire [15:0] rsp_rdata, flash_dq_o, flash_dq_i;
  wire [23:0] flash_addr;
  wire [2:0]  select_combination;
  integer     n_errors = 0, check_count = 0, k, j, w, cyc;
  always #2 mclk = ~mclk;
  afbt_host afbt_host_i (.mclk, .sys_rst, .req_valid, .req_write, .req_page, .req_std_mode,
    .req_byte_mode, .req_reset, .req_addr, .req_wdata, .prog_enable_req(prog_en),
    .req_ready, .rsp_valid, .rsp_rdata, .busy_status, .flash_addr, .flash_dq_o,
    .flash_dq_oe_n, .flash_dq_i, .select_combination, .flash_oe_n, .flash_we_n,
    .flash_byte_n, .reset_powerdown_n, .program_enable_input, .ready_status_pin);
  afbt_flash_model afbt_flash_model_i (.flash_addr, .flash_dq_o, .select_combination,
    .flash_oe_n, .flash_we_n, .reset_powerdown_n, .std_mode(req_std_mode), .flash_dq_i,
    .ready_status_pin);
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task check(input [31:0] seen, input [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want)
      begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task stop_test;
    begin
      if (n_errors == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task wait_rsp;
    begin
      cyc = 1;
      @(negedge mclk);
      while (rsp_valid !== 1'b1 && cyc < 400)
      begin
        @(negedge mclk);
        cyc = cyc + 1;
      end
      if (rsp_valid !== 1'b1)
      begin
        n_errors = n_errors + 1;
        stop_test;
      end
    end
  endtask
  task issue(input wr, input pg, input st, input rs, input [23:0] ad, input [15:0] d);
    begin
      j = 0;
      @(negedge mclk);
      while (req_ready !== 1'b1 && j < 400)
      begin
        @(negedge mclk);
        j = j + 1;
      end
      if (req_ready !== 1'b1)
      begin
        n_errors = n_errors + 1;
        stop_test;
      end
      @(posedge mclk);
      {req_valid, req_write, req_page, req_std_mode, req_reset} <= {1'b1, wr, pg, st, rs};
      req_addr <= ad;
      req_wdata <= d;
      @(posedge mclk);
      req_valid <= 1'b0;
      @(negedge mclk);
    end
  endtask
  initial
  begin
    for (k = 0; k < 256; k = k + 1)
      shadow[k] = k[15:0] ^ 16'h5a5a;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_rsp;
    check(cyc, 79);
    issue(1'b0, 1'b0, 1'b0, 1'b1, 24'h000000, 16'h0000);
    wait_rsp;
    check(cyc, 78);
    for (k = 0; k < 2; k = k + 1)
    begin
      @(posedge mclk);
      req_byte_mode <= k[0];
      issue(1'b0, 1'b0, 1'b0, 1'b0, 24'h000000, 16'h0000);
      wait_rsp;
      check(cyc, 250);
      check(flash_byte_n, k[0]);
    end
    for (k = 0; k < 24; k = k + 1)
    begin
      seed = lfsr(seed);
      a = seed[7:0];
      if (seed[9:8] == 2'h0)
      begin
        @(posedge mclk);
        prog_en <= 1'b1;
        issue(1'b1, 1'b0, 1'b0, 1'b0, {16'h0000, a}, seed[31:16]);
        shadow[a] = seed[31:16];
        wait_rsp;
        check(cyc, 23);
        @(posedge mclk);
        prog_en <= 1'b0;
        issue(1'b0, 1'b0, 1'b0, 1'b0, {16'h0000, a}, 16'h0000);
        wait_rsp;
        check(rsp_rdata, shadow[a]);
        check({busy_status, program_enable_input}, 2'h3);
      end
      else
      begin
        issue(1'b0, seed[9], seed[8], 1'b0, {16'h0000, a[7:3], 3'h0}, 16'h0000);
        for (w = 0; w < (seed[9] ? 8 : 1); w = w + 1)
        begin
          wait_rsp;
          check(cyc, (w == 0 || seed[8]) ? 21 : 9);
          check(rsp_rdata, shadow[{a[7:3], w[2:0]}]);
        end
      end
    end
    stop_test;
  end
endmodule // test_async_flash_bus_timing
